// ==== tmc_pkg.sv ====
// Package with register map, field positions and reset values for the tach mode and pin config block.
package tmc_pkg;
  localparam logic [7:0] TMC_CFG_OFFSET = 8'h05;
  localparam logic [7:0] TMC_MASK_OFFSET = 8'h20;
  localparam logic [7:0] TMC_STATUS_OFFSET = 8'h21;
  localparam int TMC_RST_EN_BIT = 7;
  localparam int TMC_ALARM_EN_BIT = 6;
  localparam int TMC_FAN2_DIV_HI = 5;
  localparam int TMC_FAN2_DIV_LO = 4;
  localparam int TMC_FAN1_DIV_HI = 3;
  localparam int TMC_FAN1_DIV_LO = 2;
  localparam int TMC_FAN2_MODE_BIT = 1;
  localparam int TMC_FAN1_MODE_BIT = 0;
  localparam logic [7:0] TMC_CFG_RESET = 8'h14;
  localparam logic [7:0] TMC_MASK_RESET = 8'h00;
  localparam logic [3:0] TMC_PRESCALE_DEFAULT = 4'h2;
  localparam int TMC_SYNC_STAGES = 3;
  typedef enum logic [2:0]
  {
    TMC_PIN_OFF = 3'b001,
    TMC_PIN_RESET = 3'b010,
    TMC_PIN_ALARM = 3'b100
  } tmc_pin_mode_t;
endpackage

// ==== tmc_fan_chan.sv ====
// One fan input channel: synchroniser, prescaled edge counter and level alarm.
`timescale 1ns/10ps
module tmc_fan_chan
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  input wire logic level_mode_i,
  input wire logic active_low_i,
  input wire logic [1:0] prescale_i,
  output logic [CNT_W-1:0] count_o,
  output logic event_o
);
  logic [TMC_SYNC_STAGES-1:0] sync;
  logic level;
  logic [3:0] pre;
  logic [CNT_W-1:0] count;
  logic ev;
  logic [TMC_SYNC_STAGES-1:0] next_sync;
  logic next_level;
  logic [3:0] next_pre;
  logic [CNT_W-1:0] next_count;
  logic next_ev;
  logic [3:0] pre_limit;
  logic [2:0] fill;
  logic [2:0] next_fill;
  logic primed;

  always_comb
  begin
    primed = (fill == 3'(TMC_SYNC_STAGES + 1));
    next_fill = primed ? fill : fill + 3'h1;
    next_sync = {sync[TMC_SYNC_STAGES-2:0], pin_i};
    // A change counts only once the second and third stages agree.
    // Until the stages have filled the level is loaded without counting, so a pin idling high is no edge.
    next_level = !primed ? sync[2] : ((sync[1] == sync[2]) ? sync[2] : level);
    pre_limit = 4'(4'h1 << prescale_i);
    next_pre = pre;
    next_count = count;
    next_ev = 1'b0;
    if (level_mode_i)
    begin
      next_pre = 4'h0;
      next_ev = active_low_i ? ~level : level; // R5 R6
    end
    else if (primed && next_level && !level)
    begin
      // Prescale: one count per 1, 2, 4 or 8 rising edges.
      if (pre + 4'h1 >= pre_limit) // R9
      begin
        next_pre = 4'h0;
        next_count = count + CNT_W'(1);
      end
      else
      begin
        next_pre = pre + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fill <= 3'h0;
      sync <= '0;
      level <= 1'b0;
      pre <= 4'h0;
      count <= '0;
      ev <= 1'b0;
    end
    else
    begin
      fill <= next_fill;
      sync <= next_sync;
      level <= next_level;
      pre <= next_pre;
      count <= next_count;
      ev <= next_ev;
    end
  end

  assign count_o = count;
  assign event_o = ev;
endmodule

// ==== tmc_top.sv ====
// Fan tach mode, divisor and shared reset/alarm pin configuration register with its steered logic.
// Functional notes
// R1 - Bit 7 set makes the shared pin carry the reset-request function.
// R2 - Bit 6 set makes the shared pin carry the overtemperature alarm.
// R3 - Alarm works only with bit 7 clear; reset request wins.
// R4 - Both bits clear leaves the shared pin disabled, nothing asserted.
// R5 - Fan 2 level mode: bit 4 one alarms on low, zero on high.
// R6 - Fan 1 level mode: bit 2 one alarms on low, zero on high.
// R7 - Bit 1 one puts fan 2 in level mode, zero in counting.
// R8 - Bit 0 one puts fan 1 in level mode, zero in counting.
// R9 - Divisor fields give prescale 1, 2, 4, 8; reset to code 1.
// R10 - A set mask bit keeps a fan status off the interrupt output.
`timescale 1ns/10ps
module tmc_top
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic fan1_pulse_input_i,
  input wire logic fan2_pulse_input_i,
  input wire logic reset_request_i,
  input wire logic overtemp_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  output logic interrupt_o,
  output logic [CNT_W-1:0] fan1_count_o,
  output logic [CNT_W-1:0] fan2_count_o
);
  logic [7:0] cfg;
  logic [1:0] mask;
  logic [1:0] status;
  logic [7:0] rdata;
  logic pin_drive;
  logic pin_oe;
  logic irq;
  logic [7:0] next_cfg;
  logic [1:0] next_mask;
  logic [1:0] next_status;
  logic [7:0] next_rdata;
  logic next_pin_drive;
  logic next_pin_oe;
  logic next_irq;
  tmc_pin_mode_t pin_mode;
  logic [1:0] fan_event;
  logic [1:0] fan_level_mode;
  logic [1:0] fan_active_low;
  logic [1:0] fan_in;
  logic [1:0][1:0] fan_prescale;
  logic [1:0][CNT_W-1:0] fan_count;

  assign fan_in = {fan2_pulse_input_i, fan1_pulse_input_i};
  assign fan_level_mode = {cfg[TMC_FAN2_MODE_BIT], cfg[TMC_FAN1_MODE_BIT]}; // R7 R8
  assign fan_active_low = {cfg[TMC_FAN2_DIV_LO], cfg[TMC_FAN1_DIV_LO]}; // R5 R6
  assign fan_prescale[1] = cfg[TMC_FAN2_DIV_HI:TMC_FAN2_DIV_LO]; // R9
  assign fan_prescale[0] = cfg[TMC_FAN1_DIV_HI:TMC_FAN1_DIV_LO]; // R9

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_fan
      tmc_fan_chan #(.CNT_W(CNT_W)) u_chan
      (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(fan_in[g]),
        .level_mode_i(fan_level_mode[g]),
        .active_low_i(fan_active_low[g]),
        .prescale_i(fan_prescale[g]),
        .count_o(fan_count[g]),
        .event_o(fan_event[g])
      );
    end
  endgenerate

  always_comb
  begin
    // Reset request takes the pin whenever bit 7 is set, regardless of bit 6.
    if (cfg[TMC_RST_EN_BIT])
      pin_mode = TMC_PIN_RESET; // R1 R3
    else if (cfg[TMC_ALARM_EN_BIT])
      pin_mode = TMC_PIN_ALARM; // R2
    else
      pin_mode = TMC_PIN_OFF; // R4
  end

  always_comb
  begin
    next_cfg = cfg;
    next_mask = mask;
    // Status is sticky; a new event wins over a clear in the same cycle.
    next_status = status;
    if (reg_write_i && reg_addr_i == TMC_CFG_OFFSET)
      next_cfg = reg_wdata_i;
    if (reg_write_i && reg_addr_i == TMC_MASK_OFFSET)
      next_mask = reg_wdata_i[1:0];
    if (reg_write_i && reg_addr_i == TMC_STATUS_OFFSET)
      next_status = status & ~reg_wdata_i[1:0];
    next_status = next_status | fan_event;
    next_irq = |(status & ~mask); // R10
    unique case (pin_mode)
      TMC_PIN_RESET:
      begin
        next_pin_oe = reset_request_i;
        next_pin_drive = 1'b0;
      end
      TMC_PIN_ALARM:
      begin
        next_pin_oe = overtemp_i;
        next_pin_drive = 1'b0;
      end
      TMC_PIN_OFF:
      begin
        next_pin_oe = 1'b0;
        next_pin_drive = 1'b0;
      end
      default:
      begin
        next_pin_oe = 1'b0;
        next_pin_drive = 1'b0;
      end
    endcase
    if (reg_addr_i == TMC_CFG_OFFSET)
      next_rdata = next_cfg;
    else if (reg_addr_i == TMC_MASK_OFFSET)
      next_rdata = {6'h00, next_mask};
    else if (reg_addr_i == TMC_STATUS_OFFSET)
      next_rdata = {6'h00, next_status};
    else
      next_rdata = 8'h00;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg <= TMC_CFG_RESET; // R9
      mask <= TMC_MASK_RESET[1:0];
      status <= 2'h0;
      rdata <= 8'h00;
      pin_drive <= 1'b0;
      pin_oe <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
      pin_drive <= next_pin_drive;
      pin_oe <= next_pin_oe;
      irq <= next_irq;
    end
  end

  assign reg_rdata_o = rdata;
  assign shared_pin_o = pin_drive;
  assign shared_pin_oe_o = pin_oe;
  assign interrupt_o = irq;
  assign fan1_count_o = fan_count[0];
  assign fan2_count_o = fan_count[1];
endmodule

// ==== tmc_checker.sv ====
// Assertions on the config register, shared pin steering, masking and count hold.
`timescale 1ns/10ps
module tmc_checker
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reset_request_i,
  input wire logic overtemp_i,
  input wire logic shared_pin_oe_o,
  input wire logic interrupt_o,
  input wire logic [CNT_W-1:0] fan1_count_o,
  input wire logic [CNT_W-1:0] fan2_count_o
);
  // Shadow copies let the properties see register state without reaching into the design.
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [1:0] msk;
  logic [1:0] next_msk;
  always_comb
  begin
    next_cfg = (reg_write_i && reg_addr_i == TMC_CFG_OFFSET) ? reg_wdata_i : cfg;
    next_msk = (reg_write_i && reg_addr_i == TMC_MASK_OFFSET) ? reg_wdata_i[1:0] : msk;
  end
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg <= TMC_CFG_RESET;
      msk <= 2'h0;
    end
    else
    begin
      cfg <= next_cfg;
      msk <= next_msk;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_pin_reset: assert property (cfg[7] |=> shared_pin_oe_o == $past(reset_request_i)) else $error("reset pin");
  chk_pin_alarm: assert property (!cfg[7] && cfg[6] |=> shared_pin_oe_o == $past(overtemp_i)) else $error("alarm");
  chk_reset_wins: assert property (cfg[7] && !reset_request_i |=> !shared_pin_oe_o) else $error("precedence");
  chk_pin_off: assert property (cfg[7:6] == 2'h0 |=> !shared_pin_oe_o) else $error("pin off");
  chk_cfg_readback: assert property (reg_addr_i == TMC_CFG_OFFSET |=> reg_rdata_o == cfg) else $error("readback");
  chk_mask_quiet: assert property (msk == 2'h3 |=> !interrupt_o) else $error("masked irq");
  chk_fan1_hold: assert property (cfg[0] |=> $stable(fan1_count_o)) else $error("fan1 count");
  chk_fan2_hold: assert property (cfg[1] |=> $stable(fan2_count_o)) else $error("fan2 count");
endmodule

// ==== tmc_fan_model.sv ====
// Fan model: a tach pin that pulses once per four cycles while spinning, else rests at a level.
`timescale 1ns/10ps
module tmc_fan_model
(
  input wire logic clk_i,
  input wire logic spin_i,
  input wire logic level_i,
  output logic pin_o
);
  logic [1:0] ph = 2'h0;
  // The phase moves on the rising edge by non-blocking assignment, so a spin change made by the bench never races it.
  always @(posedge clk_i)
  begin
    ph <= spin_i ? ph + 2'h1 : 2'h0;
  end
  assign pin_o = spin_i ? ph[1] : level_i;
endmodule

// ==== tb_tmc_top.sv ====
// Self-checking bench for the tach mode and shared pin configuration block.
`timescale 1ns/10ps
module tb_tmc_top;
  import tmc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic rr = 1'b0;
  logic ot = 1'b0;
  logic spin = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [7:0] rd;
  logic f1, f2, oe, po, irq;
  logic [15:0] c1, c2;
  int fails = 0;
  int samples_checked = 0;
  `define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("ERROR %0t %h %h", $time, a, e); end end
  always #25 clk_i = ~clk_i;
  tmc_fan_model fm1_u (.clk_i(clk_i), .spin_i(spin), .level_i(lvl[0]), .pin_o(f1));
  tmc_fan_model fm2_u (.clk_i(clk_i), .spin_i(spin), .level_i(lvl[1]), .pin_o(f2));
  tmc_top #(.CNT_W(16)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_write_i(wr),
    .reg_wdata_i(wd), .reg_rdata_o(rd), .fan1_pulse_input_i(f1), .fan2_pulse_input_i(f2), .reset_request_i(rr),
    .overtemp_i(ot), .shared_pin_o(po), .shared_pin_oe_o(oe), .interrupt_o(irq), .fan1_count_o(c1), .fan2_count_o(c2));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
  begin
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
  begin
    addr = a;
    cyc(1);
    `CMP(rd, e);
  end
  endtask
  task automatic give_verdict;
  begin
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task automatic t_reset;
  begin
    rreg(TMC_CFG_OFFSET, 8'h14);
    rreg(TMC_MASK_OFFSET, 8'h00);
    rreg(8'h33, 8'h00);
    `CMP(oe, 1'b0);
    `CMP(irq, 1'b0);
    `CMP(c1, 16'h0000);
    `CMP(c2, 16'h0000);
  end
  endtask
  task automatic t_rerun;
  begin
    wreg(TMC_CFG_OFFSET, 8'hC3);
    reset_i = 1'b1;
    cyc(2);
    reset_i = 1'b0;
    cyc(1);
    t_reset;
  end
  endtask
  task automatic t_pin;
    int i;
  begin
    for (i = 0; i < 4; i++)
    begin
      wreg(TMC_CFG_OFFSET, {i[1:0], 6'h14});
      rr = 1'b1;
      ot = 1'b0;
      cyc(3);
      `CMP(oe, i[1]);
      rr = 1'b0;
      ot = 1'b1;
      cyc(3);
      `CMP(oe, i == 1);
      `CMP(po, 1'b0);
    end
    ot = 1'b0;
  end
  endtask
  task automatic t_count;
    int c;
    logic [15:0] b1, b2;
  begin
    for (c = 0; c < 4; c++)
    begin
      wreg(TMC_CFG_OFFSET, {2'b00, c[1:0], c[1:0], 2'b00});
      b1 = c1;
      b2 = c2;
      spin = 1'b1;
      cyc(64);
      spin = 1'b0;
      cyc(8);
      `CMP(c1 - b1, 16'(16 >> c));
      `CMP(c2 - b2, 16'(16 >> c));
    end
  end
  endtask
  task automatic t_level;
    int p;
    int k;
  begin
    for (p = 0; p < 2; p++)
    begin
      lvl = {2{p[0]}};
      wreg(TMC_CFG_OFFSET, {3'b000, p[0], 1'b0, p[0], 2'b11});
      cyc(8);
      wreg(TMC_STATUS_OFFSET, 8'h03);
      `CMP(irq, 1'b0);
      lvl = ~lvl;
      for (k = 0; k < 12 && irq !== 1'b1; k++)
        cyc(1);
      `CMP(irq, 1'b1);
      if (irq !== 1'b1)
        give_verdict;
      rreg(TMC_STATUS_OFFSET, 8'h03);
      wreg(TMC_MASK_OFFSET, 8'h03);
      `CMP(irq, 1'b0);
      rreg(TMC_STATUS_OFFSET, 8'h03);
      wreg(TMC_MASK_OFFSET, 8'h00);
    end
  end
  endtask
  initial
  begin
    cyc(8);
    reset_i = 1'b0;
    cyc(1);
    t_reset;
    t_pin;
    t_count;
    t_level;
    t_rerun;
    give_verdict;
  end
endmodule
bind tmc_top tmc_checker #(.CNT_W(CNT_W)) chk_u (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reset_request_i(reset_request_i),
  .overtemp_i(overtemp_i), .shared_pin_oe_o(shared_pin_oe_o), .interrupt_o(interrupt_o),
  .fan1_count_o(fan1_count_o), .fan2_count_o(fan2_count_o));
